/* core/pmc_pkg.sv */
package pmc_pkg;
	// ************************************************************
	// register command codes
	// ************************************************************
	localparam logic [7:0] ADDR_CURRENT_GAIN_CALIBRATION = 8'h38;
	localparam logic [7:0] ADDR_BUS_VOLTAGE_RESULT = 8'h8B;
	localparam logic [7:0] ADDR_CURRENT_RESULT = 8'h8C;
	localparam logic [7:0] ADDR_DIE_TEMPERATURE_RESULT = 8'h8D;
	localparam logic [7:0] ADDR_POWER_RESULT = 8'h96;
	localparam logic [7:0] ADDR_BUS_CHANNEL_ACQUISITION_CONFIG = 8'hD5;
	localparam logic [7:0] ADDR_SHUNT_VOLTAGE_RESULT = 8'hD6;
	localparam logic [7:0] ADDR_PEAK_TRACKING_CONFIG = 8'hD7;
	localparam logic [7:0] ADDR_MIN_CURRENT_RESULT = 8'hD8;
	localparam logic [7:0] ADDR_MAX_CURRENT_RESULT = 8'hD9;
	localparam logic [7:0] ADDR_AUX_VOLTAGE_RESULT = 8'hE1;
	localparam logic [7:0] ADDR_CONVERSION_STATUS = 8'hD3;
	// ************************************************************
	// reset values and fields
	// ************************************************************
	localparam logic [15:0] RST_CURRENT_GAIN_CALIBRATION = 16'h0000;
	localparam logic [15:0] RST_BUS_CHANNEL_ACQUISITION_CONFIG = 16'h0387;
	localparam logic [7:0] RST_PEAK_TRACKING_CONFIG = 8'h00;
	localparam logic [15:0] MASK_CAL_GAIN = 16'h7FFF;
	localparam logic [15:0] MASK_BUS_CFG = 16'h3FFF;
	localparam logic [7:0] MASK_PEAK_CFG = 8'h01;
	localparam int AUX_AVG_LSB = 10;
	localparam int AUX_CT_LSB = 7;
	localparam int BUS_AVG_LSB = 3;
	localparam int BUS_CT_LSB = 0;
	localparam int MATH_RES_BITS = 11;
	localparam int SHUNT_RES = 32768;
	localparam int POWER_SHIFT = 15;
	// ************************************************************
	// conversion timing
	// ************************************************************
	localparam int CLK_MHZ = 40;
	localparam int CONV_TIME_BASE_US = 64;
	localparam int CONV_BASE_CYCLES = CONV_TIME_BASE_US * CLK_MHZ;
	localparam logic [15:0] MIN_INIT = 16'h7FFF;
	localparam logic [15:0] MAX_INIT = 16'h8000;
	typedef enum logic [2:0] {
		PMC_IDLE = 3'b001,
		PMC_CUR = 3'b010,
		PMC_PWR = 3'b100
	} pmc_state_t;
endpackage : pmc_pkg

/* core/pmc_math.sv */
module pmc_math (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic start,
	input wire logic [15:0] shunt,
	input wire logic [15:0] vbus,
	input wire logic [14:0] gain,
	output logic done,
	output logic [15:0] current,
	output logic [15:0] power,
	output logic overflow
);
	import pmc_pkg::*;

	pmc_state_t state;
	logic signed [31:0] cur_prod;
	logic signed [32:0] pwr_prod;
	logic signed [31:0] cur_scaled;
	logic signed [32:0] pwr_scaled;

	function automatic logic fits16(input logic signed [32:0] v);
		fits16 = (v <= 33'sd32767) && (v >= -33'sd32768);
	endfunction : fits16

	assign cur_prod = $signed(shunt) * $signed({1'b0, gain});
	assign cur_scaled = cur_prod >>> MATH_RES_BITS;
	assign pwr_prod = $signed(current) * $signed({1'b0, vbus});
	assign pwr_scaled = pwr_prod >>> POWER_SHIFT;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= PMC_IDLE;
			done <= 1'b0;
			current <= 16'h0000;
			power <= 16'h0000;
			overflow <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				PMC_IDLE: begin
					if (start) begin
						state <= PMC_CUR;
					end
				end
				PMC_CUR: begin
					// current = shunt * gain / 2048
					current <= cur_scaled[15:0];
					overflow <= !fits16({cur_scaled[31], cur_scaled});
					state <= PMC_PWR;
				end
				PMC_PWR: begin
					power <= pwr_scaled[15:0];
					if (!fits16(pwr_scaled)) begin
						overflow <= 1'b1;
					end
					done <= 1'b1;
					state <= PMC_IDLE;
				end
				default: begin
					state <= PMC_IDLE;
				end
			endcase
		end
	end
endmodule : pmc_math

/* core/pmc_core.sv */
// Function
// - averaging code n gives 2^n samples up to 2048; codes 11xx give 4096
// - nonzero calibration gain enables current and power computation
// - calibration gain is 15 bits, bit 15 reads zero, resets to zero
// - internal math resolution is 2048, an 11-bit shift
// - shunt result is signed 15-bit magnitude, 32768 steps
// - bus config: aux avg 13:10, aux time 9:7, bus avg 6:3, bus time 2:0
// - bus and aux fields use the shunt field code mapping
// - conversion time codes 64,128,256,512us, 10x 1.024ms, 11x 2.048ms
// - peak config bit 0 enables min/max current tracking, others zero
// - each current result updates min and max while tracking enabled
// - clearing enable stops tracking and resets min and max
// - only current is tracked, not voltage power or temperature
// - shunt voltage result is a signed word, 2.5uV per count
// - bus voltage result is unsigned word, 1mV or 250uV step
// - current result is signed, from shunt and calibration gain
// - power result is signed, from current and bus voltage
// - aux voltage result is unsigned, 100uV per count
// - temperature is 16-bit two's complement, 0.016 C per count
// - math overflow flag raised when current or power out of range
module pmc_core #(
	parameter int AVG_MAX = 4096
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_hit,
	input wire logic conv_done,
	input wire logic [15:0] conv_shunt,
	input wire logic [15:0] conv_vbus,
	input wire logic [15:0] conv_aux,
	input wire logic [15:0] conv_temp,
	output logic [12:0] bus_averaging_count,
	output logic [12:0] aux_averaging_count,
	output logic [17:0] bus_conv_cycles,
	output logic [17:0] aux_conv_cycles,
	output logic math_overflow_flag
);
	import pmc_pkg::*;

	// ************************************************************
	// storage
	// ************************************************************
	logic [15:0] current_gain_calibration;
	logic [15:0] bus_channel_acquisition_config;
	logic [7:0] peak_tracking_config;
	logic [15:0] shunt_voltage_result;
	logic [15:0] bus_voltage_result;
	logic [15:0] aux_voltage_result;
	logic [15:0] die_temperature_result;
	logic [15:0] min_current_result;
	logic [15:0] max_current_result;
	logic [15:0] current_result;
	logic [15:0] power_result;
	logic math_done;
	logic math_ovf;
	logic [15:0] shunt_clamped;
	logic [15:0] next_rdata;
	logic next_hit;
	logic track_en;

	// ************************************************************
	// code decoders
	// ************************************************************
	function automatic logic [12:0] avg_samples(input logic [3:0] code);
		if (code[3:2] == 2'b11) begin
			avg_samples = 13'(AVG_MAX);
		end else begin
			avg_samples = 13'h0001 << code;
		end
	endfunction : avg_samples

	function automatic logic [17:0] conv_cycles(input logic [2:0] code);
		logic [17:0] base;
		base = 18'(CONV_BASE_CYCLES);
		if (code[2]) begin
			conv_cycles = base << (code[1] ? 5 : 4);
		end else begin
			conv_cycles = base << code[1:0];
		end
	endfunction : conv_cycles

	assign track_en = peak_tracking_config[0];

	// ************************************************************
	// writable registers
	// ************************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			current_gain_calibration <= RST_CURRENT_GAIN_CALIBRATION;
			bus_channel_acquisition_config <= RST_BUS_CHANNEL_ACQUISITION_CONFIG;
			peak_tracking_config <= RST_PEAK_TRACKING_CONFIG;
		end else if (reg_wr) begin
			// result addresses fall through untouched
			case (reg_addr)
				ADDR_CURRENT_GAIN_CALIBRATION: begin
					current_gain_calibration <= reg_wdata & MASK_CAL_GAIN;
				end
				ADDR_BUS_CHANNEL_ACQUISITION_CONFIG: begin
					bus_channel_acquisition_config <= reg_wdata & MASK_BUS_CFG;
				end
				ADDR_PEAK_TRACKING_CONFIG: begin
					peak_tracking_config <= reg_wdata[7:0] & MASK_PEAK_CFG;
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// acquisition settings
	// ************************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bus_averaging_count <= 13'h0001;
			aux_averaging_count <= 13'h0001;
			bus_conv_cycles <= 18'h00000;
			aux_conv_cycles <= 18'h00000;
		end else begin
			bus_averaging_count <= avg_samples(bus_channel_acquisition_config[BUS_AVG_LSB +: 4]);
			aux_averaging_count <= avg_samples(bus_channel_acquisition_config[AUX_AVG_LSB +: 4]);
			bus_conv_cycles <= conv_cycles(bus_channel_acquisition_config[BUS_CT_LSB +: 3]);
			aux_conv_cycles <= conv_cycles(bus_channel_acquisition_config[AUX_CT_LSB +: 3]);
		end
	end

	// ************************************************************
	// raw conversion results
	// ************************************************************
	// shunt limited to a signed 15-bit magnitude
	always_comb begin
		if (conv_shunt == 16'h8000) begin
			shunt_clamped = 16'h8001;
		end else begin
			shunt_clamped = conv_shunt;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			shunt_voltage_result <= 16'h0000;
			bus_voltage_result <= 16'h0000;
			aux_voltage_result <= 16'h0000;
			die_temperature_result <= 16'h0000;
		end else if (conv_done) begin
			shunt_voltage_result <= shunt_clamped;
			bus_voltage_result <= conv_vbus;
			aux_voltage_result <= conv_aux;
			die_temperature_result <= conv_temp;
		end
	end

	// ************************************************************
	// current and power arithmetic
	// ************************************************************
	pmc_math u_math (
		.mclk(mclk),
		.nrst(nrst),
		.start(conv_done && (current_gain_calibration[14:0] != 15'h0000)),
		// math works from the stored results, the live inputs may already have moved on
		.shunt(shunt_voltage_result),
		.vbus(bus_voltage_result),
		.gain(current_gain_calibration[14:0]),
		.done(math_done),
		.current(current_result),
		.power(power_result),
		.overflow(math_ovf)
	);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			math_overflow_flag <= 1'b0;
		end else if (math_done) begin
			math_overflow_flag <= math_ovf;
		end
	end

	// ************************************************************
	// peak tracking
	// ************************************************************
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			min_current_result <= MIN_INIT;
			max_current_result <= MAX_INIT;
		end else if (!track_en) begin
			min_current_result <= MIN_INIT;
			max_current_result <= MAX_INIT;
		end else if (math_done) begin
			// only current feeds the trackers
			if ($signed(current_result) < $signed(min_current_result)) begin
				min_current_result <= current_result;
			end
			if ($signed(current_result) > $signed(max_current_result)) begin
				max_current_result <= current_result;
			end
		end
	end

	// ************************************************************
	// read port
	// ************************************************************
	always_comb begin
		next_hit = 1'b1;
		case (reg_addr)
			ADDR_CURRENT_GAIN_CALIBRATION: next_rdata = current_gain_calibration;
			ADDR_BUS_VOLTAGE_RESULT: next_rdata = bus_voltage_result;
			ADDR_CURRENT_RESULT: next_rdata = current_result;
			ADDR_DIE_TEMPERATURE_RESULT: next_rdata = die_temperature_result;
			ADDR_POWER_RESULT: next_rdata = power_result;
			ADDR_BUS_CHANNEL_ACQUISITION_CONFIG: next_rdata = bus_channel_acquisition_config;
			ADDR_SHUNT_VOLTAGE_RESULT: next_rdata = shunt_voltage_result;
			ADDR_PEAK_TRACKING_CONFIG: next_rdata = {8'h00, peak_tracking_config};
			ADDR_MIN_CURRENT_RESULT: next_rdata = min_current_result;
			ADDR_MAX_CURRENT_RESULT: next_rdata = max_current_result;
			ADDR_AUX_VOLTAGE_RESULT: next_rdata = aux_voltage_result;
			ADDR_CONVERSION_STATUS: next_rdata = {15'h0000, math_overflow_flag};
			default: begin
				next_rdata = 16'h0000;
				next_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
			reg_hit <= 1'b0;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
			reg_hit <= next_hit;
		end else begin
			reg_hit <= 1'b0;
		end
	end
endmodule : pmc_core

/* tb/pmc_core_assertions.sv */
module pmc_core_assertions #(
	parameter int AVG_MAX = 4096
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_hit,
	input wire logic conv_done,
	input wire logic [12:0] bus_averaging_count,
	input wire logic [12:0] aux_averaging_count,
	input wire logic [17:0] bus_conv_cycles,
	input wire logic [17:0] aux_conv_cycles,
	input wire logic math_overflow_flag
);
	import pmc_pkg::*;
	logic [15:0] cfg;
	logic [1:0] wh;
	// last configuration written, and write history to let decode settle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cfg <= RST_BUS_CHANNEL_ACQUISITION_CONFIG;
			wh <= 2'h3;
		end else begin
			wh <= {wh[0], reg_wr};
			if (reg_wr && reg_addr == ADDR_BUS_CHANNEL_ACQUISITION_CONFIG) begin
				cfg <= reg_wdata;
			end
		end
	end
	function automatic logic [12:0] averaging_count(input logic [3:0] c);
		return (c[3:2] == 2'h3) ? 13'(AVG_MAX) : 13'(1 << c);
	endfunction : averaging_count
	function automatic logic [17:0] cyc(input logic [2:0] c);
		return c[2] ? (c[1] ? 18'h14000 : 18'h0A000) : 18'(18'h00A00 << c[1:0]);
	endfunction : cyc
	function automatic logic mapped(input logic [7:0] a);
		return a inside {8'h38, 8'h8B, 8'h8C, 8'h8D, 8'h96, 8'hD3, 8'hD5, 8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'hE1};
	endfunction : mapped
	bus_avg_a: assert property (@(posedge mclk) disable iff (!nrst)
		wh == 2'h0 |-> bus_averaging_count == averaging_count(cfg[6:3])) else $error("bus averaging decode wrong");
	aux_avg_a: assert property (@(posedge mclk) disable iff (!nrst)
		wh == 2'h0 |-> aux_averaging_count == averaging_count(cfg[13:10])) else $error("aux averaging decode wrong");
	bus_time_a: assert property (@(posedge mclk) disable iff (!nrst)
		wh == 2'h0 |-> bus_conv_cycles == cyc(cfg[2:0])) else $error("bus conversion time wrong");
	aux_time_a: assert property (@(posedge mclk) disable iff (!nrst)
		wh == 2'h0 |-> aux_conv_cycles == cyc(cfg[9:7])) else $error("aux conversion time wrong");
	hit_map_a: assert property (@(posedge mclk) disable iff (!nrst)
		reg_rd |=> reg_hit == mapped($past(reg_addr))) else $error("read hit wrong");
	unmap_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
		reg_rd && !mapped(reg_addr) |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
	rdata_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		!reg_rd |=> $stable(reg_rdata)) else $error("read data moved without read");
	gain_msb_a: assert property (@(posedge mclk) disable iff (!nrst)
		reg_rd && reg_addr == 8'h38 |=> !reg_rdata[15]) else $error("gain bit 15 set");
	peak_bits_a: assert property (@(posedge mclk) disable iff (!nrst)
		reg_rd && reg_addr == 8'hD7 |=> reg_rdata[15:1] == 15'h0000) else $error("peak config high bits set");
	flag_cause_a: assert property (@(posedge mclk) disable iff (!nrst)
		$changed(math_overflow_flag) |-> $past(conv_done, 4)) else $error("overflow flag moved without math");
endmodule : pmc_core_assertions

/* tb/pmc_host_model.sv */
module pmc_host_model (
	input wire logic mclk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_hit
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end
	// idle bus shows inverted last values so stale data never passes
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic h);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
		h = reg_hit;
	endtask : rd
endmodule : pmc_host_model

/* tb/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pmc_pkg::*;
	logic mclk, nrst, reg_wr, reg_rd, reg_hit, conv_done, math_overflow_flag, h;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, conv_shunt, conv_vbus, conv_aux, conv_temp, d, p;
	logic [12:0] bus_averaging_count, aux_averaging_count;
	logic [17:0] bus_conv_cycles, aux_conv_cycles;
	int num_errors = 0;
	int n_compared = 0;
	pmc_core i_pmc_core (.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .conv_done(conv_done),
		.conv_shunt(conv_shunt), .conv_vbus(conv_vbus), .conv_aux(conv_aux), .conv_temp(conv_temp),
		.bus_averaging_count(bus_averaging_count), .aux_averaging_count(aux_averaging_count),
		.bus_conv_cycles(bus_conv_cycles), .aux_conv_cycles(aux_conv_cycles),
		.math_overflow_flag(math_overflow_flag));
	pmc_host_model i_pmc_host_model (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
	always #12.5 mclk = ~mclk;
	task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
		i_pmc_host_model.rd(a, d, h);
		chk(n, {2'h0, e}, {2'h0, d});
	endtask : rchk
	task automatic conv(input logic [15:0] s, input logic [15:0] v, input logic [15:0] x, input logic [15:0] t);
		@(posedge mclk);
		conv_done <= 1'b1;
		{conv_shunt, conv_vbus, conv_aux, conv_temp} <= {s, v, x, t};
		@(posedge mclk);
		conv_done <= 1'b0;
		{conv_shunt, conv_vbus, conv_aux, conv_temp} <= ~{s, v, x, t};
		repeat (4) @(posedge mclk);
	endtask : conv
	task automatic t_reset();
		rchk("gain", 8'h38, 16'h0000);
		rchk("cfg", 8'hD5, 16'h0387);
		rchk("peak", 8'hD7, 16'h0000);
		chk("bus_avg", 18'h00001, {5'h00, bus_averaging_count});
		chk("bus_cyc", 18'h14000, bus_conv_cycles);
		chk("aux_cyc", 18'h14000, aux_conv_cycles);
	endtask : t_reset
	task automatic t_regs();
		i_pmc_host_model.wr(8'h38, 16'hFFFF);
		rchk("gain", 8'h38, 16'h7FFF);
		i_pmc_host_model.wr(8'hD7, 16'hFFFF);
		rchk("peak", 8'hD7, 16'h0001);
		i_pmc_host_model.wr(8'hD7, 16'h0000);
		i_pmc_host_model.rd(8'h8C, p, h);
		i_pmc_host_model.wr(8'h8C, ~p);
		rchk("current_ro", 8'h8C, p);
		i_pmc_host_model.rd(8'h40, d, h);
		chk("unmapped_hit", 18'h00000, {17'h00000, h});
	endtask : t_regs
	task automatic t_cfg();
		for (int c = 0; c < 16; c++) begin
			i_pmc_host_model.wr(8'hD5, {2'h0, 4'(c), 3'(c), 4'(c), 3'(c)});
			repeat (3) @(posedge mclk);
			chk("bus_avg", (c >= 12) ? 18'h01000 : 18'(1 << c), {5'h00, bus_averaging_count});
			chk("aux_avg", (c >= 12) ? 18'h01000 : 18'(1 << c), {5'h00, aux_averaging_count});
			p[2:0] = 3'(c);
			d = p[2] ? (p[1] ? 16'h0800 : 16'h0400) : 16'(16'h0040 << p[1:0]);
			chk("bus_cyc", 18'(d * 40), bus_conv_cycles);
			chk("aux_cyc", 18'(d * 40), aux_conv_cycles);
		end
		i_pmc_host_model.wr(8'hD5, 16'hFFFF);
		rchk("cfg", 8'hD5, 16'h3FFF);
	endtask : t_cfg
	task automatic t_raw();
		i_pmc_host_model.wr(8'h38, 16'h0000);
		i_pmc_host_model.rd(8'h8C, p, h);
		conv(16'hFE00, 16'hF000, 16'h1234, 16'hFF80);
		rchk("shunt", 8'hD6, 16'hFE00);
		rchk("vbus", 8'h8B, 16'hF000);
		rchk("aux", 8'hE1, 16'h1234);
		rchk("temp", 8'h8D, 16'hFF80);
		rchk("current_nogain", 8'h8C, p);
	endtask : t_raw
	task automatic t_math();
		i_pmc_host_model.wr(8'h38, 16'h0100);
		conv(16'h0800, 16'h1000, 16'h0000, 16'h0000);
		rchk("current", 8'h8C, 16'h0100);
		rchk("power", 8'h96, 16'h0020);
		conv(16'hF800, 16'h1000, 16'h0000, 16'h0000);
		rchk("current_neg", 8'h8C, 16'hFF00);
		rchk("power_neg", 8'h96, 16'hFFE0);
	endtask : t_math
	task automatic t_peak();
		i_pmc_host_model.wr(8'hD7, 16'h0001);
		conv(16'h0800, 16'h1000, 16'h0000, 16'h0000);
		conv(16'hF800, 16'h1000, 16'h0000, 16'h0000);
		conv(16'h0400, 16'h1000, 16'h0000, 16'h0000);
		rchk("min", 8'hD8, 16'hFF00);
		rchk("max", 8'hD9, 16'h0100);
		i_pmc_host_model.wr(8'hD7, 16'h0000);
		rchk("min_clr", 8'hD8, 16'h7FFF);
		conv(16'h0800, 16'h1000, 16'h0000, 16'h0000);
		rchk("max_off", 8'hD9, 16'h8000);
	endtask : t_peak
	task automatic t_ovf();
		i_pmc_host_model.wr(8'h38, 16'h0800);
		conv(16'h8000, 16'h0001, 16'h0000, 16'h0000);
		rchk("current_clamp", 8'h8C, 16'h8001);
		i_pmc_host_model.rd(8'hD3, d, h);
		chk("ovf_clear", 18'h00000, {17'h00000, d[0]});
		i_pmc_host_model.wr(8'h38, 16'h7FFF);
		conv(16'h7FFF, 16'h7FFF, 16'h0000, 16'h0000);
		i_pmc_host_model.rd(8'hD3, d, h);
		chk("ovf_set", 18'h00001, {17'h00000, d[0]});
		chk("ovf_port", 18'h00001, {17'h00000, math_overflow_flag});
	endtask : t_ovf
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run
	initial begin
		#2000000;
		num_errors++;
		complete_run();
	end
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		conv_done = 1'b0;
		{conv_shunt, conv_vbus, conv_aux, conv_temp} = 64'h0;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		t_reset();
		t_regs();
		t_cfg();
		t_raw();
		t_math();
		t_peak();
		t_ovf();
		complete_run();
	end
endmodule : tb_top
bind pmc_core pmc_core_assertions #(.AVG_MAX(AVG_MAX)) i_pmc_core_assertions (.mclk(mclk), .nrst(nrst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_hit(reg_hit), .conv_done(conv_done), .bus_averaging_count(bus_averaging_count),
	.aux_averaging_count(aux_averaging_count), .bus_conv_cycles(bus_conv_cycles),
	.aux_conv_cycles(aux_conv_cycles), .math_overflow_flag(math_overflow_flag));
